// file: bth_pkg.sv
// barrier handler package: barrier-type and domain encodings, response codes,
// responder states and the decision on whether this node may answer a barrier.
// assumes a coherent-bus address channel with a 2-bit barrier-type and domain field.
package bth_pkg;

   // domain field encodings
   localparam logic [1:0] DOM_NONSH = 2'h0;
   localparam logic [1:0] DOM_INNER = 2'h1;
   localparam logic [1:0] DOM_OUTER = 2'h2;
   localparam logic [1:0] DOM_SYSTEM = 2'h3;

   // barrier-type field bit positions
   localparam int BAR_IS_BARRIER_BIT = 0;
   localparam int BAR_SYNC_BIT = 1;

   // the only response a barrier may carry
   localparam logic [1:0] RESP_OKAY = 2'h0;

   // outstanding barriers an issuing master may hold at most
   localparam int MAX_OUTSTANDING = 256;
   // counter value after reset
   localparam int CNT_RESET_VAL = 0;

   typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_RESP} bth_state_t;

   // bit 0 set marks a barrier; otherwise bit 1 tells respect or ignore
   function automatic logic bth_is_barrier(input logic [1:0] bar);
      return bar[BAR_IS_BARRIER_BIT];
   endfunction : bth_is_barrier

   // may a node whose boundary reaches 'boundary' answer this barrier itself
   function automatic logic bth_can_answer(input logic [1:0] domain,
                                           input logic sync,
                                           input logic [1:0] boundary,
                                           input logic endpoint_resp);
      if (domain == DOM_SYSTEM) begin
         // system sync needs endpoint responses; memory needs system boundary
         return sync ? endpoint_resp : (boundary == DOM_SYSTEM);
      end
      // non-shareable always passes; inner and outer need their boundary
      return (domain <= boundary); // RULE_12 RULE_13 RULE_14
   endfunction : bth_can_answer

endpackage : bth_pkg

// file: bth_bar_if.sv
// per-channel carrier between the barrier handler top and its helpers:
// outstanding count events, barrier capture and local response handshake.
// assumes one instance per address channel, all on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface bth_bar_if #(
   parameter int ID_W = 4
);
   logic issue;
   logic retire;
   logic drained;
   logic take;
   logic [ID_W-1:0] take_id;
   logic resp_valid;
   logic resp_ready;
   logic [ID_W-1:0] resp_id;
   logic busy;

   modport top (output issue, output retire, output take, output take_id,
                output resp_ready, input drained, input resp_valid,
                input resp_id, input busy);
   modport cnt (input issue, input retire, output drained);
   modport rsp (input take, input take_id, input resp_ready, input drained,
                output resp_valid, output resp_id, output busy);
endinterface : bth_bar_if
`default_nettype wire

// file: bth_outstanding_counter.sv
// counts transactions sent downstream on one channel and not yet answered.
// assumes issue and retire are single-cycle handshake strobes.
`timescale 1ns/1ps
`default_nettype none
module bth_outstanding_counter #(
   parameter int CNT_W = 9
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   bth_bar_if.cnt chan_io
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   // issue and retire in one cycle cancel out
   assign cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, chan_io.issue}
                        - {{(CNT_W-1){1'b0}}, chan_io.retire};
   assign chan_io.drained = (cnt_q == '0);

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= CNT_W'(bth_pkg::CNT_RESET_VAL);
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : bth_outstanding_counter
`default_nettype wire

// file: bth_barrier_responder.sv
// holds one locally answered barrier: waits for its channel to drain,
// then offers a response until the master takes it.
// assumes the top blocks its channel while busy is high.
`timescale 1ns/1ps
`default_nettype none
module bth_barrier_responder #(
   parameter int ID_W = 4
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   bth_bar_if.rsp chan_io
);
   bth_pkg::bth_state_t state_q;
   bth_pkg::bth_state_t state_d;
   logic [ID_W-1:0] id_q;

   assign chan_io.busy = (state_q != bth_pkg::ST_IDLE);
   assign chan_io.resp_valid = (state_q == bth_pkg::ST_RESP); // RULE_02
   assign chan_io.resp_id = id_q; // RULE_06

   // answer only once every earlier transaction has been answered downstream
   always_comb begin
      state_d = state_q;
      case (state_q)
         bth_pkg::ST_IDLE: begin
            if (chan_io.take) state_d = bth_pkg::ST_DRAIN;
         end
         bth_pkg::ST_DRAIN: begin
            if (chan_io.drained) state_d = bth_pkg::ST_RESP; // RULE_16
         end
         bth_pkg::ST_RESP: begin
            if (chan_io.resp_ready) state_d = bth_pkg::ST_IDLE;
         end
         default: state_d = bth_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= bth_pkg::ST_IDLE;
         id_q <= '0;
      end else begin
         state_q <= state_d;
         if (chan_io.take) id_q <= chan_io.take_id;
      end
   end

   // a response once offered stays until taken, with the same id
   property p_resp_hold;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      chan_io.resp_valid && !chan_io.resp_ready |=>
         chan_io.resp_valid && $stable(chan_io.resp_id);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("barrier response dropped"); // RULE_02

   // no response before the channel has drained
   property p_drain_gate;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      $rose(chan_io.resp_valid) |-> $past(chan_io.drained);
   endproperty
   a_drain_gate: assert property (p_drain_gate) else $error("answered before drain"); // RULE_17

   // once drained the response follows in the next cycle
   property p_resp_prompt;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (state_q == bth_pkg::ST_DRAIN) && chan_io.drained |=> chan_io.resp_valid;
   endproperty
   a_resp_prompt: assert property (p_resp_prompt) else $error("late barrier response"); // RULE_02
endmodule : bth_barrier_responder
`default_nettype wire

// file: bth_barrier_handler.sv
// barrier handler for one coherent interconnect port: forwards normal
// transactions and barriers it may not answer, answers the rest itself.
// assumes upstream master and downstream slave on the same clock; write data
// bypasses this block since barriers carry none.
// How it works
// RULE_01: the master sends every barrier as a read and write address pair.
// RULE_02: each barrier half gets a response on its own response channel.
// RULE_03: a write barrier has no data beats, only address and response.
// RULE_04: per channel, anything issued before its barrier is pre-barrier.
// RULE_05: post-barrier means issued after both barrier responses arrived.
// RULE_06: response id equals the id of the barrier request.
// RULE_07: barrier responses are okay; read side single beat with last high.
// RULE_08: read data during a barrier response is any value, ignored.
// RULE_09: user sideband on barrier transfers should be all zeros.
// RULE_10: barrier-type field separates barriers, barrier kinds and respect flag.
// RULE_11: normal traffic should respect barriers unless ordering-free streams.
// RULE_12: non-shareable barrier orders only its own stream.
// RULE_13: inner shareable barrier orders against all inner domain masters.
// RULE_14: outer shareable barrier orders against all outer domain masters.
// RULE_15: system barrier orders all; system sync waits for endpoint arrival.
// RULE_16: memory barrier: seeing post-barrier implies seeing all pre-barrier.
// RULE_17: sync barrier completion makes all earlier transfers observable.
// RULE_18: both pair halves carry equal id, type, domain and protection.
// RULE_19: answer memory barrier only at or beyond its boundary.
// RULE_20: answer non-system sync only at boundary, else forward downstream.
// RULE_21: an answering node makes earlier crossings visible to later ones.
`timescale 1ns/1ps
`default_nettype none
module bth_barrier_handler #(
   parameter int ID_W = 4,
   parameter int ADDR_W = 32,
   parameter int DATA_W = 64,
   parameter int USER_W = 4,
   parameter int CNT_W = 9,
   parameter logic [1:0] BOUNDARY_DOMAIN = bth_pkg::DOM_SYSTEM,
   parameter logic ENDPOINT_RESP = 1'b1
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // upstream read address
   input wire logic up_arvalid_in,
   output logic up_arready_out,
   input wire logic [ID_W-1:0] up_arid_in,
   input wire logic [ADDR_W-1:0] up_araddr_in,
   input wire logic [1:0] up_arbar_in,
   input wire logic [1:0] up_ardomain_in,
   // upstream read data
   output logic up_rvalid_out,
   input wire logic up_rready_in,
   output logic [ID_W-1:0] up_rid_out,
   output logic [DATA_W-1:0] up_rdata_out,
   output logic [1:0] up_rresp_out,
   output logic up_rlast_out,
   output logic [USER_W-1:0] up_ruser_out,
   // upstream write address
   input wire logic up_awvalid_in,
   output logic up_awready_out,
   input wire logic [ID_W-1:0] up_awid_in,
   input wire logic [ADDR_W-1:0] up_awaddr_in,
   input wire logic [1:0] up_awbar_in,
   input wire logic [1:0] up_awdomain_in,
   // upstream write response
   output logic up_bvalid_out,
   input wire logic up_bready_in,
   output logic [ID_W-1:0] up_bid_out,
   output logic [1:0] up_bresp_out,
   output logic [USER_W-1:0] up_buser_out,
   // downstream read address
   output logic dn_arvalid_out,
   input wire logic dn_arready_in,
   output logic [ID_W-1:0] dn_arid_out,
   output logic [ADDR_W-1:0] dn_araddr_out,
   output logic [1:0] dn_arbar_out,
   output logic [1:0] dn_ardomain_out,
   // downstream read data
   input wire logic dn_rvalid_in,
   output logic dn_rready_out,
   input wire logic [ID_W-1:0] dn_rid_in,
   input wire logic [DATA_W-1:0] dn_rdata_in,
   input wire logic [1:0] dn_rresp_in,
   input wire logic dn_rlast_in,
   input wire logic [USER_W-1:0] dn_ruser_in,
   // downstream write address
   output logic dn_awvalid_out,
   input wire logic dn_awready_in,
   output logic [ID_W-1:0] dn_awid_out,
   output logic [ADDR_W-1:0] dn_awaddr_out,
   output logic [1:0] dn_awbar_out,
   output logic [1:0] dn_awdomain_out,
   // downstream write response
   input wire logic dn_bvalid_in,
   output logic dn_bready_out,
   input wire logic [ID_W-1:0] dn_bid_in,
   input wire logic [1:0] dn_bresp_in,
   input wire logic [USER_W-1:0] dn_buser_in
);
   bth_bar_if #(.ID_W(ID_W)) rd_if ();
   bth_bar_if #(.ID_W(ID_W)) wr_if ();

   logic ar_is_bar;
   logic ar_local;
   logic aw_is_bar;
   logic aw_local;
   logic r_local;
   logic b_local;

   // classify each address request: barrier kind and whether we answer it
   assign ar_is_bar = bth_pkg::bth_is_barrier(up_arbar_in); // RULE_10
   assign aw_is_bar = bth_pkg::bth_is_barrier(up_awbar_in); // RULE_10
   assign ar_local = ar_is_bar && bth_pkg::bth_can_answer(up_ardomain_in, // RULE_19
      up_arbar_in[bth_pkg::BAR_SYNC_BIT], BOUNDARY_DOMAIN, ENDPOINT_RESP); // RULE_20
   assign aw_local = aw_is_bar && bth_pkg::bth_can_answer(up_awdomain_in, // RULE_19
      up_awbar_in[bth_pkg::BAR_SYNC_BIT], BOUNDARY_DOMAIN, ENDPOINT_RESP); // RULE_20

   // read address: hold the channel while a local barrier drains, so nothing
   // issued after it can overtake what went before it on this channel
   assign dn_arvalid_out = up_arvalid_in && !ar_local && !rd_if.busy; // RULE_04
   assign up_arready_out = !rd_if.busy && (ar_local || dn_arready_in); // RULE_21
   assign dn_arid_out = up_arid_in;
   assign dn_araddr_out = up_araddr_in;
   assign dn_arbar_out = up_arbar_in; // RULE_20
   assign dn_ardomain_out = up_ardomain_in;
   assign rd_if.take = up_arvalid_in && ar_local && !rd_if.busy;
   assign rd_if.take_id = up_arid_in;
   assign rd_if.issue = dn_arvalid_out && dn_arready_in;
   assign rd_if.retire = dn_rvalid_in && dn_rready_out && dn_rlast_in;

   // write address: same scheme; barrier writes send no data beats
   assign dn_awvalid_out = up_awvalid_in && !aw_local && !wr_if.busy; // RULE_04
   assign up_awready_out = !wr_if.busy && (aw_local || dn_awready_in); // RULE_21
   assign dn_awid_out = up_awid_in;
   assign dn_awaddr_out = up_awaddr_in;
   assign dn_awbar_out = up_awbar_in; // RULE_20
   assign dn_awdomain_out = up_awdomain_in;
   assign wr_if.take = up_awvalid_in && aw_local && !wr_if.busy; // RULE_03
   assign wr_if.take_id = up_awid_in;
   assign wr_if.issue = dn_awvalid_out && dn_awready_in;
   assign wr_if.retire = dn_bvalid_in && dn_bready_out;

   // read response: local answer only when the channel is empty, so the
   // downstream path is idle and no arbitration is needed
   assign r_local = rd_if.resp_valid;
   assign rd_if.resp_ready = up_rready_in;
   assign up_rvalid_out = r_local || dn_rvalid_in; // RULE_02
   assign dn_rready_out = up_rready_in && !r_local; // RULE_05
   assign up_rid_out = r_local ? rd_if.resp_id : dn_rid_in; // RULE_06
   assign up_rdata_out = r_local ? '0 : dn_rdata_in; // RULE_08
   assign up_rresp_out = r_local ? bth_pkg::RESP_OKAY : dn_rresp_in; // RULE_07
   assign up_rlast_out = r_local || dn_rlast_in; // RULE_07
   assign up_ruser_out = r_local ? '0 : dn_ruser_in; // RULE_09

   // write response: one beat, okay, zero user sideband when answered here
   assign b_local = wr_if.resp_valid;
   assign wr_if.resp_ready = up_bready_in;
   assign up_bvalid_out = b_local || dn_bvalid_in; // RULE_02
   assign dn_bready_out = up_bready_in && !b_local; // RULE_05
   assign up_bid_out = b_local ? wr_if.resp_id : dn_bid_in; // RULE_06
   assign up_bresp_out = b_local ? bth_pkg::RESP_OKAY : dn_bresp_in; // RULE_07
   assign up_buser_out = b_local ? '0 : dn_buser_in; // RULE_09

   // per-channel outstanding counters; a barrier waits for zero, which also
   // covers system sync since answers come back from the endpoints
   bth_outstanding_counter #(.CNT_W(CNT_W)) u_rd_cnt (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .chan_io(rd_if.cnt)
   ); // RULE_15
   bth_outstanding_counter #(.CNT_W(CNT_W)) u_wr_cnt (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .chan_io(wr_if.cnt)
   ); // RULE_15

   bth_barrier_responder #(.ID_W(ID_W)) u_rd_rsp (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .chan_io(rd_if.rsp)
   );
   bth_barrier_responder #(.ID_W(ID_W)) u_wr_rsp (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .chan_io(wr_if.rsp)
   );

   // checking only: id of the last locally taken barrier per channel
   logic [ID_W-1:0] chk_ar_id_q;
   logic [ID_W-1:0] chk_aw_id_q;
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         chk_ar_id_q <= '0;
         chk_aw_id_q <= '0;
      end else begin
         if (up_arvalid_in && up_arready_out && ar_local) chk_ar_id_q <= up_arid_in;
         if (up_awvalid_in && up_awready_out && aw_local) chk_aw_id_q <= up_awid_in;
      end
   end

   sequence s_ar_take;
      up_arvalid_in && up_arready_out && ar_local;
   endsequence
   sequence s_aw_take;
      up_awvalid_in && up_awready_out && aw_local;
   endsequence

   property p_r_okay;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      r_local |-> up_rvalid_out && up_rresp_out == 2'h0 && up_rlast_out;
   endproperty
   a_r_okay: assert property (p_r_okay) else $error("bad read barrier response"); // RULE_07

   property p_b_okay;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      b_local |-> up_bvalid_out && up_bresp_out == 2'h0 && up_buser_out == '0;
   endproperty
   a_b_okay: assert property (p_b_okay) else $error("bad write barrier response"); // RULE_07

   property p_r_id;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      r_local |-> up_rid_out == chk_ar_id_q && up_ruser_out == '0;
   endproperty
   a_r_id: assert property (p_r_id) else $error("read barrier id mismatch"); // RULE_06

   property p_b_id;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      b_local |-> up_bid_out == chk_aw_id_q;
   endproperty
   a_b_id: assert property (p_b_id) else $error("write barrier id mismatch"); // RULE_06

   // a taken barrier blocks its channel for at least drain and response cycles
   property p_ar_block;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      s_ar_take |=> (!up_arready_out && !dn_arvalid_out) [*2];
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read channel not blocked"); // RULE_21

   property p_aw_block;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      s_aw_take |=> (!up_awready_out && !dn_awvalid_out) [*2];
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write channel not blocked"); // RULE_21

   // a barrier this node may not answer goes downstream unchanged
   property p_ar_fwd;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      up_arvalid_in && ar_is_bar && !ar_local && !rd_if.busy |->
         dn_arvalid_out && dn_arid_out == up_arid_in && dn_arbar_out == up_arbar_in;
   endproperty
   a_ar_fwd: assert property (p_ar_fwd) else $error("read barrier not forwarded"); // RULE_20

   // system sync is answered here only with nothing outstanding on that side
   property p_sys_sync;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      s_aw_take ##1 !b_local [*1] ##1 b_local |-> $past(wr_if.drained);
   endproperty
   a_sys_sync: assert property (p_sys_sync) else $error("answered with writes pending"); // RULE_15
endmodule : bth_barrier_handler
`default_nettype wire

// file: bth_slave_model.sv
// downstream slave model for the barrier handler: takes every address at once,
// answers reads with one beat and writes with one response after a delay.
// assumes it faces the handler's downstream ports on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bth_slave_model #(
   parameter int ID_W = 4,
   parameter int DATA_W = 64,
   parameter int USER_W = 4
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic slow_in,
   input wire logic dn_arvalid_in,
   output logic dn_arready_out,
   input wire logic [ID_W-1:0] dn_arid_in,
   output logic dn_rvalid_out,
   input wire logic dn_rready_in,
   output logic [ID_W-1:0] dn_rid_out,
   output logic [DATA_W-1:0] dn_rdata_out,
   output logic [1:0] dn_rresp_out,
   output logic dn_rlast_out,
   output logic [USER_W-1:0] dn_ruser_out,
   input wire logic dn_awvalid_in,
   output logic dn_awready_out,
   input wire logic [ID_W-1:0] dn_awid_in,
   output logic dn_bvalid_out,
   input wire logic dn_bready_in,
   output logic [ID_W-1:0] dn_bid_out,
   output logic [1:0] dn_bresp_out,
   output logic [USER_W-1:0] dn_buser_out
);
   logic [ID_W-1:0] rq[$];
   logic [ID_W-1:0] bq[$];
   int rwait;
   int bwait;
   int lat;

   // a slow slave answers late so that drain logic upstream is exercised
   assign lat = slow_in ? 24 : 1;
   assign dn_arready_out = 1'b1;
   assign dn_awready_out = 1'b1;
   // okay code, single beat, user zero on every answer
   assign dn_rresp_out = 2'h0;
   assign dn_rlast_out = 1'b1;
   assign dn_ruser_out = '0;
   assign dn_bresp_out = 2'h0;
   assign dn_buser_out = '0;

   // answer in order on the channel the request came in on, with its id;
   // read data flips after each beat so a stale value is never mistaken
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rq.delete();
         bq.delete();
         rwait = 0;
         bwait = 0;
         dn_rvalid_out <= 1'b0;
         dn_bvalid_out <= 1'b0;
         dn_rid_out <= '0;
         dn_bid_out <= '0;
         dn_rdata_out <= '0;
      end else begin
         if (dn_arvalid_in && dn_arready_out) rq.push_back(dn_arid_in);
         if (dn_awvalid_in && dn_awready_out) bq.push_back(dn_awid_in);
         if (dn_rvalid_out && dn_rready_in) begin
            dn_rvalid_out <= 1'b0;
            dn_rdata_out <= ~dn_rdata_out;
         end else if (!dn_rvalid_out && rq.size() > 0) begin
            rwait = rwait + 1;
            if (rwait > lat) begin
               dn_rvalid_out <= 1'b1;
               dn_rid_out <= rq.pop_front();
               rwait = 0;
            end
         end
         if (dn_bvalid_out && dn_bready_in) begin
            dn_bvalid_out <= 1'b0;
         end else if (!dn_bvalid_out && bq.size() > 0) begin
            bwait = bwait + 1;
            if (bwait > lat) begin
               dn_bvalid_out <= 1'b1;
               dn_bid_out <= bq.pop_front();
               bwait = 0;
            end
         end
      end
   end
endmodule : bth_slave_model
`default_nettype wire

// file: tb.sv
// testbench for the barrier handler: a bench master upstream, slave model below.
// assumes the handler sits at an inner boundary with no endpoint responses,
// so low-domain barriers are answered here and the rest go downstream.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int ID_W = 4;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int USER_W = 4;
   localparam logic [1:0] BOUND = bth_pkg::DOM_INNER;
   logic clk_sys_in, arst_n_in, slow;
   logic up_arvalid_in, up_arready_out, up_rvalid_out, up_rready_in, up_rlast_out;
   logic up_awvalid_in, up_awready_out, up_bvalid_out, up_bready_in;
   logic dn_arvalid_out, dn_arready_in, dn_rvalid_in, dn_rready_out, dn_rlast_in;
   logic dn_awvalid_out, dn_awready_in, dn_bvalid_in, dn_bready_out;
   logic [ID_W-1:0] up_arid_in, up_rid_out, up_awid_in, up_bid_out;
   logic [ID_W-1:0] dn_arid_out, dn_rid_in, dn_awid_out, dn_bid_in;
   logic [ADDR_W-1:0] up_araddr_in, up_awaddr_in, dn_araddr_out, dn_awaddr_out;
   logic [DATA_W-1:0] up_rdata_out, dn_rdata_in;
   logic [1:0] up_arbar_in, up_ardomain_in, up_rresp_out, up_awbar_in, up_awdomain_in;
   logic [1:0] up_bresp_out, dn_arbar_out, dn_ardomain_out, dn_rresp_in;
   logic [1:0] dn_awbar_out, dn_awdomain_out, dn_bresp_in;
   logic [USER_W-1:0] up_ruser_out, up_buser_out, dn_ruser_in, dn_buser_in;
   int mismatches = 0;
   int tests_run = 0;

   bth_barrier_handler #(.BOUNDARY_DOMAIN(BOUND), .ENDPOINT_RESP(1'b0)) u_dut (
      .clk_sys_in, .arst_n_in, .up_arvalid_in, .up_arready_out, .up_arid_in,
      .up_araddr_in, .up_arbar_in, .up_ardomain_in, .up_rvalid_out, .up_rready_in,
      .up_rid_out, .up_rdata_out, .up_rresp_out, .up_rlast_out, .up_ruser_out,
      .up_awvalid_in, .up_awready_out, .up_awid_in, .up_awaddr_in, .up_awbar_in,
      .up_awdomain_in, .up_bvalid_out, .up_bready_in, .up_bid_out, .up_bresp_out,
      .up_buser_out, .dn_arvalid_out, .dn_arready_in, .dn_arid_out, .dn_araddr_out,
      .dn_arbar_out, .dn_ardomain_out, .dn_rvalid_in, .dn_rready_out, .dn_rid_in,
      .dn_rdata_in, .dn_rresp_in, .dn_rlast_in, .dn_ruser_in, .dn_awvalid_out,
      .dn_awready_in, .dn_awid_out, .dn_awaddr_out, .dn_awbar_out, .dn_awdomain_out,
      .dn_bvalid_in, .dn_bready_out, .dn_bid_in, .dn_bresp_in, .dn_buser_in);

   bth_slave_model u_slave (
      .clk_sys_in, .arst_n_in, .slow_in(slow), .dn_arvalid_in(dn_arvalid_out),
      .dn_arready_out(dn_arready_in), .dn_arid_in(dn_arid_out),
      .dn_rvalid_out(dn_rvalid_in), .dn_rready_in(dn_rready_out),
      .dn_rid_out(dn_rid_in), .dn_rdata_out(dn_rdata_in), .dn_rresp_out(dn_rresp_in),
      .dn_rlast_out(dn_rlast_in), .dn_ruser_out(dn_ruser_in),
      .dn_awvalid_in(dn_awvalid_out), .dn_awready_out(dn_awready_in),
      .dn_awid_in(dn_awid_out), .dn_bvalid_out(dn_bvalid_in),
      .dn_bready_in(dn_bready_out), .dn_bid_out(dn_bid_in),
      .dn_bresp_out(dn_bresp_in), .dn_buser_out(dn_buser_in));

   // free-running system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // present one address and hold it until taken; judge where it went
   task automatic send(input bit w, input logic [3:0] id, input logic [1:0] bar,
                       input logic [1:0] dom, input bit fwd);
      int n;
      n = 0;
      @(negedge clk_sys_in);
      up_arid_in = id;
      up_awid_in = id;
      up_arbar_in = bar;
      up_awbar_in = bar;
      up_ardomain_in = dom;
      up_awdomain_in = dom;
      up_araddr_in = {24'h0, id, 4'h0};
      up_awaddr_in = {24'h0, id, 4'h8};
      if (w) up_awvalid_in = 1'b1;
      else up_arvalid_in = 1'b1;
      // give the combinational forward path time to settle before looking
      #1;
      while ((w ? up_awready_out : up_arready_out) !== 1'b1 && n < 100) begin
         @(negedge clk_sys_in);
         n++;
      end
      chk("dn valid", fwd, w ? dn_awvalid_out : dn_arvalid_out);
      if (fwd) chk("dn fields", {id, bar, dom, w ? up_awaddr_in : up_araddr_in},
         w ? {dn_awid_out, dn_awbar_out, dn_awdomain_out, dn_awaddr_out}
           : {dn_arid_out, dn_arbar_out, dn_ardomain_out, dn_araddr_out});
      @(negedge clk_sys_in);
      up_arvalid_in = 1'b0;
      up_awvalid_in = 1'b0;
      // a held local barrier blocks its own channel
      if (!fwd) chk("held ready", 0, w ? up_awready_out : up_arready_out);
   endtask : send

   // wait for one response on the chosen side, judge it, then accept it
   task automatic expect_resp(input bit w, input logic [3:0] id, input int limit);
      int n;
      n = 0;
      while ((w ? up_bvalid_out : up_rvalid_out) !== 1'b1 && n < limit) begin
         @(negedge clk_sys_in);
         n++;
      end
      chk("resp valid", 1, w ? up_bvalid_out : up_rvalid_out);
      chk("resp id", id, w ? up_bid_out : up_rid_out);
      chk("resp code", 0, w ? up_bresp_out : up_rresp_out);
      chk("resp user", 0, w ? up_buser_out : up_ruser_out);
      if (!w) chk("read last", 1, up_rlast_out);
      // forwarded read data must pass through; a local barrier's data is ignored
      if (!w && dn_rvalid_in === 1'b1) chk("read data", dn_rdata_in, up_rdata_out);
      if (w) up_bready_in = 1'b1;
      else up_rready_in = 1'b1;
      @(negedge clk_sys_in);
      up_rready_in = 1'b0;
      up_bready_in = 1'b0;
   endtask : expect_resp

   // every barrier kind and domain, plus both normal kinds, as read/write pairs
   task automatic t_decide();
      logic [1:0] bars[9] = '{2'h1, 2'h3, 2'h1, 2'h3, 2'h1, 2'h3, 2'h1, 2'h3, 2'h0};
      logic [1:0] doms[9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
      bit fwd;
      for (int i = 0; i < 10; i++) begin
         fwd = (i == 9) || !bars[i % 9][0] || doms[i % 9] > BOUND;
         send(0, i[3:0], (i == 9) ? 2'h2 : bars[i % 9], doms[i % 9], fwd);
         send(1, i[3:0], (i == 9) ? 2'h2 : bars[i % 9], doms[i % 9], fwd);
         expect_resp(0, i[3:0], 60);
         expect_resp(1, i[3:0], 60);
      end
   endtask : t_decide

   // local barriers wait for slow earlier traffic on their own channel only
   task automatic t_drain();
      slow = 1'b1;
      send(0, 4'h5, 2'h0, 2'h0, 1);
      send(0, 4'h6, 2'h3, 2'h0, 0);
      send(1, 4'h7, 2'h0, 2'h0, 1);
      expect_resp(0, 4'h5, 80);
      expect_resp(0, 4'h6, 2);
      send(1, 4'h6, 2'h3, 2'h0, 0);
      expect_resp(1, 4'h7, 80);
      expect_resp(1, 4'h6, 2);
      slow = 1'b0;
   endtask : t_drain

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   // main sequence: idle inputs, reset for 8 cycles, then the scenarios
   initial begin
      {arst_n_in, slow, up_arvalid_in, up_awvalid_in, up_rready_in, up_bready_in} = '0;
      {up_arid_in, up_awid_in, up_arbar_in, up_awbar_in} = '0;
      {up_ardomain_in, up_awdomain_in, up_araddr_in, up_awaddr_in} = '0;
      repeat (8) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      arst_n_in = 1'b1;
      t_decide();
      t_drain();
      end_of_test();
   end

   // hang guard: far beyond what the scenarios need
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      mismatches++;
      end_of_test();
   end
endmodule : tb
`default_nettype wire
